// [verilog/biphase_tx_pkg.sv]
`default_nettype none
package biphase_tx_pkg;
    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_TRANSMITTER_CONFIG = 10'h0ae;
    localparam logic [9:0] IDX_TRANSMITTER_CONTROL = 10'h0c8;
    localparam logic [9:0] IDX_TX_DATA_BUFFER = 10'h0c9;
    localparam logic [9:0] IDX_TX_ENCODER_CONTROL = 10'h0ca;
    localparam logic [9:0] IDX_TX_ENCODER_STATUS = 10'h0cb;
    localparam logic [9:0] IDX_BIT_TIMER_RELOAD = 10'h0d0;
    // reset values
    localparam logic [7:0] RST_TX_DATA_BUFFER = 8'h00;
    localparam logic [7:0] RST_TX_ENCODER_CONTROL = 8'he0;
    localparam logic [7:0] RST_TRANSMITTER_CONTROL = 8'h00;
    localparam logic [7:0] RST_TRANSMITTER_CONFIG = 8'h87;
    localparam logic [15:0] RST_BIT_TIMER_RELOAD = 16'h0000;
    // writable bits of transmitter_control
    localparam logic [7:0] MASK_TRANSMITTER_CONTROL = 8'h83;
    // field positions
    localparam int POS_BIT_COUNT_SELECT = 5;
    localparam int POS_IDLE_LEVEL_SELECT = 3;
    localparam int POS_ENCODING_SELECT = 0;
    localparam int POS_LOCK_MONITOR_ENABLE = 7;
    localparam int POS_MANUAL_AMP_ENABLE = 0;
    localparam int POS_MODULATION_SELECT = 5;
    localparam int POS_PA_FORCED_OFF_STATUS = 7;
    localparam int POS_SHIFTER_EMPTY_FLAG = 1;
    localparam int POS_BUFFER_FULL_FLAG = 0;
    // encoding_select codes
    localparam logic [2:0] ENC_MANCHESTER = 3'h0;
    localparam logic [2:0] ENC_INV_MANCHESTER = 3'h1;
    localparam logic [2:0] ENC_DIFF_MANCHESTER = 3'h2;
    localparam logic [2:0] ENC_BIPHASE_ZERO = 3'h3;
    localparam logic [2:0] ENC_BIPHASE_ONE = 3'h4;
    localparam logic [2:0] ENC_CHIP = 3'h5;
    // bit timing: timer periods per bit and per half bit
    localparam int TIMER_PER_BIT = 8;
    localparam logic [2:0] PHASE_HALF_END = 3'(TIMER_PER_BIT / 2 - 1);
    localparam logic [2:0] PHASE_BIT_END = 3'(TIMER_PER_BIT - 1);

    typedef struct packed {
        logic [7:0] enc_ctrl;
        logic [7:0] tx_ctrl;
        logic [7:0] tx_cfg;
        logic [15:0] reload;
        logic [15:0] timer;
        logic [2:0] phase;
        logic [7:0] buffer;
        logic buf_full;
        logic [7:0] shreg;
        logic [3:0] bits_left;
        logic empty;
        logic pa_dis;
        logic [2:0] mode;
        logic level;
        logic enc_out;
        logic pa_en;
        logic resume;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } state_type;

    localparam state_type ST_RESET = '{
        enc_ctrl: RST_TX_ENCODER_CONTROL, tx_ctrl: RST_TRANSMITTER_CONTROL,
        tx_cfg: RST_TRANSMITTER_CONFIG, reload: RST_BIT_TIMER_RELOAD, timer: 16'h0000,
        phase: 3'h0, buffer: RST_TX_DATA_BUFFER, buf_full: 1'b0, shreg: 8'h00,
        bits_left: 4'h0, empty: 1'b1, pa_dis: 1'b0, mode: 3'h0, level: 1'b0,
        enc_out: 1'b0, pa_en: 1'b0, resume: 1'b0, pready: 1'b0, pslverr: 1'b0,
        prdata: 32'h0000_0000};
endpackage
`default_nettype wire

// [verilog/rf_biphase_tx_encoder.sv]
`timescale 1ns/1ps
`default_nettype none
// How it works
// R01: bit period is eight crystal timer periods
// R02: mode and length latched at buffer transfer
// R03: while shifting, output modulated; PA per modulation
// R04: when empty, output idle level; PA per manual
// R05: length field selects one to eight MSBs
// R06: chip mode sends bits unencoded
// R07: mode codes select the six encodings
// R08: data write sets full; transfer clears it
// R09: buffer-full clearing raises a resume event
// R10: empty flag set when bits run out, PA off unless manual PA set
// R11: software keeps feeding bytes without gaps
// R12: lost lock while sending forces PA off, sticky status
// R13: encoding continues while PA forced off
// R14: idle level picks carrier state when empty
// R15: debug pin routing needs manual PA set
// R16: data register write-only, resets zero; control E0
// R17: modulation select: zero FSK, one ASK
// R18: forced-off status cleared by zero write when empty
// R19: MSB first, two four-period halves per bit
// R20: pending byte loads at boundary without gap
module rf_biphase_tx_encoder (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pll_locked,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic encoder_out,
    output logic pa_enable,
    output logic resume_event
);
    // which register a bus address selects
    typedef enum {
        SEL_NONE,
        SEL_CONFIG,
        SEL_CONTROL,
        SEL_DATA,
        SEL_ENC,
        SEL_STATUS,
        SEL_RELOAD
    } reg_sel_type;

    biphase_tx_pkg::state_type s_q;
    biphase_tx_pkg::state_type s_d;
    reg_sel_type sel;
    logic access_now;
    logic write_now;
    logic read_now;
    logic tick;
    logic bit_end;
    logic load_now;
    logic prev_end;
    logic second_half;
    logic modulated;
    logic idle_level;
    logic ask_mode;
    logic manual_pa;
    logic [7:0] shifted;
    logic [7:0] status_word;

    // address decode, shared by the read and the write path
    function automatic reg_sel_type decode_reg(input logic [11:0] addr);
        reg_sel_type sel_f;
        sel_f = SEL_NONE;
        if (addr[1:0] == 2'b00) begin
            case (addr[11:2])
                biphase_tx_pkg::IDX_TRANSMITTER_CONFIG: begin
                    sel_f = SEL_CONFIG;
                end
                biphase_tx_pkg::IDX_TRANSMITTER_CONTROL: begin
                    sel_f = SEL_CONTROL;
                end
                biphase_tx_pkg::IDX_TX_DATA_BUFFER: begin
                    sel_f = SEL_DATA;
                end
                biphase_tx_pkg::IDX_TX_ENCODER_CONTROL: begin
                    sel_f = SEL_ENC;
                end
                biphase_tx_pkg::IDX_TX_ENCODER_STATUS: begin
                    sel_f = SEL_STATUS;
                end
                biphase_tx_pkg::IDX_BIT_TIMER_RELOAD: begin
                    sel_f = SEL_RELOAD;
                end
                default: begin
                    sel_f = SEL_NONE;
                end
            endcase
        end
        return sel_f;
    endfunction

    // does the line flip in the middle of a bit
    function automatic logic mid_flip(input logic [2:0] mode, input logic data_bit);
        logic flip;
        flip = 1'b0;
        case (mode)
            biphase_tx_pkg::ENC_DIFF_MANCHESTER: flip = 1'b1;
            biphase_tx_pkg::ENC_BIPHASE_ZERO: flip = ~data_bit;
            biphase_tx_pkg::ENC_BIPHASE_ONE: flip = data_bit;
            default: flip = 1'b0;
        endcase
        return flip;
    endfunction

    // does the line flip at the start of a bit
    function automatic logic start_flip(input logic [2:0] mode, input logic data_bit);
        logic flip;
        flip = 1'b0;
        case (mode)
            biphase_tx_pkg::ENC_DIFF_MANCHESTER: flip = ~data_bit;
            biphase_tx_pkg::ENC_BIPHASE_ZERO: flip = 1'b1;
            biphase_tx_pkg::ENC_BIPHASE_ONE: flip = 1'b1;
            default: flip = 1'b0;
        endcase
        return flip;
    endfunction

    // line level for one half of a bit in every encoding
    function automatic logic line_level(input logic [2:0] mode, input logic data_bit,
        input logic half, input logic level);
        logic out;
        out = data_bit;
        case (mode)
            biphase_tx_pkg::ENC_MANCHESTER: out = data_bit ^ half; // R07
            biphase_tx_pkg::ENC_INV_MANCHESTER: out = ~data_bit ^ half; // R07
            biphase_tx_pkg::ENC_DIFF_MANCHESTER: out = level ^ (half & mid_flip(mode, data_bit));
            biphase_tx_pkg::ENC_BIPHASE_ZERO: out = level ^ (half & mid_flip(mode, data_bit));
            biphase_tx_pkg::ENC_BIPHASE_ONE: out = level ^ (half & mid_flip(mode, data_bit));
            default: out = data_bit; // R06
        endcase
        return out;
    endfunction

    // length code to number of bits sent
    function automatic logic [3:0] sent_bits(input logic [2:0] len_code);
        logic [3:0] count;
        count = {1'b0, len_code} + 4'h1; // R05
        return count;
    endfunction

    // shift one place toward the msb, zero fill at the bottom
    for (genvar i = 0; i < 8; i++) begin : g_shift
        if (i == 0) begin : g_low
            assign shifted[i] = 1'b0;
        end else begin : g_up
            assign shifted[i] = s_q.shreg[i - 1]; // R19
        end
    end

    // next state: bus, bit timer, shifter, line and amplifier control
    always_comb begin
        s_d = s_q;
        sel = decode_reg(paddr);
        access_now = psel && penable && s_q.pready;
        write_now = access_now && pwrite;
        read_now = psel && penable && !s_q.pready && !pwrite;
        tick = (s_q.timer == 16'h0000);
        bit_end = tick && (s_q.phase == biphase_tx_pkg::PHASE_BIT_END);
        load_now = 1'b0;
        prev_end = s_q.level ^ mid_flip(s_q.mode, s_q.shreg[7]);
        status_word = 8'h00;
        status_word[biphase_tx_pkg::POS_PA_FORCED_OFF_STATUS] = s_q.pa_dis;
        status_word[biphase_tx_pkg::POS_SHIFTER_EMPTY_FLAG] = s_q.empty;
        status_word[biphase_tx_pkg::POS_BUFFER_FULL_FLAG] = s_q.buf_full;

        // one wait state: pready rises one cycle into the access phase
        s_d.pready = psel && penable && !s_q.pready;
        s_d.pslverr = psel && penable && !s_q.pready && (sel == SEL_NONE);
        if (read_now) begin
            case (sel)
                SEL_CONFIG: s_d.prdata = {24'h000000, s_q.tx_cfg};
                SEL_CONTROL: s_d.prdata = {24'h000000, s_q.tx_ctrl};
                SEL_ENC: s_d.prdata = {24'h000000, s_q.enc_ctrl};
                SEL_STATUS: s_d.prdata = {24'h000000, status_word};
                SEL_RELOAD: s_d.prdata = {16'h0000, s_q.reload};
                default: s_d.prdata = 32'h0000_0000; // R16
            endcase
        end

        // register writes take effect at the completing edge only
        if (write_now) begin
            case (sel)
                SEL_CONFIG: s_d.tx_cfg = pwdata[7:0]; // R17
                SEL_CONTROL: s_d.tx_ctrl = pwdata[7:0] & biphase_tx_pkg::MASK_TRANSMITTER_CONTROL;
                SEL_ENC: s_d.enc_ctrl = pwdata[7:0];
                SEL_RELOAD: s_d.reload = pwdata[15:0];
                default: begin
                end
            endcase
        end

        // bit timer: eight timer periods per bit, reload+1 clocks each
        if (!s_q.empty) begin
            if (tick) begin
                s_d.timer = s_q.reload; // R01
                s_d.phase = s_q.phase + 3'h1; // R01
            end else begin
                s_d.timer = s_q.timer - 16'h0001;
            end
        end

        // bit boundary: next bit, gapless reload or end of frame
        if (!s_q.empty && bit_end) begin
            if (s_q.bits_left > 4'h1) begin
                s_d.shreg = shifted; // R19
                s_d.bits_left = s_q.bits_left - 4'h1;
                s_d.level = prev_end ^ start_flip(s_q.mode, shifted[7]);
            end else if (s_q.buf_full) begin
                load_now = 1'b1; // R20
            end else begin
                s_d.empty = 1'b1; // R10
                s_d.bits_left = 4'h0;
            end
        end else if (s_q.empty && s_q.buf_full) begin
            load_now = 1'b1;
        end

        // buffer to shifter; mode and length are latched here only
        if (load_now) begin
            s_d.shreg = s_q.buffer;
            s_d.bits_left = sent_bits(s_q.enc_ctrl[biphase_tx_pkg::POS_BIT_COUNT_SELECT +: 3]); // R05
            s_d.mode = s_q.enc_ctrl[biphase_tx_pkg::POS_ENCODING_SELECT +: 3]; // R02
            s_d.buf_full = 1'b0; // R08
            s_d.empty = 1'b0;
            s_d.timer = s_q.reload;
            s_d.phase = 3'h0;
            s_d.level = (s_q.empty ? s_q.enc_ctrl[biphase_tx_pkg::POS_IDLE_LEVEL_SELECT] : prev_end)
                ^ start_flip(s_q.enc_ctrl[biphase_tx_pkg::POS_ENCODING_SELECT +: 3], s_q.buffer[7]);
        end
        s_d.resume = load_now; // R09

        // a data write refills the buffer; the set wins over a transfer
        if (write_now && (sel == SEL_DATA)) begin
            s_d.buffer = pwdata[7:0];
            s_d.buf_full = 1'b1; // R08
        end

        // lock loss while sending forces the amplifier off, sticky
        if (s_q.tx_ctrl[biphase_tx_pkg::POS_LOCK_MONITOR_ENABLE] && !s_q.empty && !pll_locked) begin
            s_d.pa_dis = 1'b1; // R12
        end else if (write_now && (sel == SEL_STATUS) && s_q.empty
            && !pwdata[biphase_tx_pkg::POS_PA_FORCED_OFF_STATUS]) begin
            s_d.pa_dis = 1'b0; // R18
        end

        // line and amplifier from the next state, so outputs are flops
        second_half = (s_d.phase > biphase_tx_pkg::PHASE_HALF_END); // R19
        modulated = line_level(s_d.mode, s_d.shreg[7], second_half, s_d.level);
        idle_level = s_d.enc_ctrl[biphase_tx_pkg::POS_IDLE_LEVEL_SELECT];
        ask_mode = s_d.tx_cfg[biphase_tx_pkg::POS_MODULATION_SELECT]; // R17
        manual_pa = s_d.tx_ctrl[biphase_tx_pkg::POS_MANUAL_AMP_ENABLE];
        if (!s_d.empty) begin
            s_d.enc_out = modulated; // R03
            s_d.pa_en = ask_mode ? modulated : 1'b1; // R03
        end else begin
            s_d.enc_out = idle_level; // R14
            s_d.pa_en = manual_pa && (ask_mode ? idle_level : 1'b1); // R04
        end
        // the shifter keeps running; only the amplifier is gated
        if (s_d.pa_dis) begin
            s_d.pa_en = 1'b0; // R13
        end
    end

    // single state register; ce low freezes everything except srst, which still resets it
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s_q <= biphase_tx_pkg::ST_RESET; // R16
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign encoder_out = s_q.enc_out;
    assign pa_enable = s_q.pa_en;
    assign resume_event = s_q.resume;

    // checks share one clock; reset and a frozen clock enable mute them
    default clocking cb_main @(posedge sys_clk);
    endclocking
    default disable iff (srst || !ce);

    // empty shifter shows the idle level
    AST_EMPTY_IDLE: assert property (s_q.empty |-> encoder_out == s_q.enc_ctrl[biphase_tx_pkg::POS_IDLE_LEVEL_SELECT]) // R04
        else $error("line not at idle level while empty");
    // automatic amplifier control switches off at end of frame
    AST_PA_AUTO_OFF: assert property (s_q.empty && !s_q.tx_ctrl[biphase_tx_pkg::POS_MANUAL_AMP_ENABLE] |-> !pa_enable) // R10
        else $error("amplifier on while empty in automatic mode");
    // frequency keying keeps the amplifier on while sending
    AST_PA_FSK_ON: assert property (!s_q.empty && !s_q.tx_cfg[biphase_tx_pkg::POS_MODULATION_SELECT] && !s_q.pa_dis
        |-> pa_enable) // R03
        else $error("amplifier off while sending with frequency keying");
    // amplitude keying lets the amplifier follow the line
    AST_PA_ASK_MOD: assert property (!s_q.empty && s_q.tx_cfg[biphase_tx_pkg::POS_MODULATION_SELECT] && !s_q.pa_dis
        |-> pa_enable == encoder_out) // R03
        else $error("amplifier does not follow the line in amplitude keying");
    // forced-off status wins over everything
    AST_PA_FORCED: assert property (s_q.pa_dis |-> !pa_enable) // R12
        else $error("amplifier on while forced off");
    // a transfer raises the resume event for one cycle only
    AST_RESUME_PULSE: assert property (resume_event |=> !resume_event) // R09
        else $error("resume event longer than one cycle");
    // a transfer always leaves bits in the shifter
    AST_RESUME_LOADED: assert property (resume_event |-> !s_q.empty && s_q.bits_left != 4'h0) // R08
        else $error("transfer left the shifter empty");
    // forced-off status cannot clear while bits remain
    AST_PA_FORCED_OFF_STATUS_STICKY: assert property (s_q.pa_dis && !s_q.empty |=> s_q.pa_dis) // R18
        else $error("forced-off status cleared while sending");
    // bus answer lasts one cycle
    AST_PREADY_PULSE: assert property (pready |=> !pready) // R16
        else $error("pready held longer than one cycle");

    // main scenarios
    COV_GAPLESS_LOAD: cover property (!s_q.empty ##1 resume_event);
    COV_CHIP_BYTE: cover property (resume_event && s_q.mode == biphase_tx_pkg::ENC_CHIP);
    COV_LOCK_LOSS: cover property (!s_q.pa_dis ##1 s_q.pa_dis);
    COV_ASK_SHIFT: cover property (!s_q.empty && s_q.tx_cfg[biphase_tx_pkg::POS_MODULATION_SELECT]);
endmodule
`default_nettype wire

// [sim/pll_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module pll_partner (
    input wire logic sys_clk,
    input wire logic lose_lock,
    output logic pll_locked
);
    // synthesiser lock seen one cycle after the request
    always_ff @(posedge sys_clk) pll_locked <= !lose_lock;
endmodule
`default_nettype wire

// [sim/rf_biphase_tx_encoder_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module rf_biphase_tx_encoder_bench;
    logic sys_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
    logic pready, pslverr, enc, pa, res, locked;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic [7:0] exp_q[$];
    logic lose_lock = 0;
    logic [7:0] b;
    logic [15:0] dat_q[$], seen2, e2;
    int fail_count = 0, check_count = 0, n;
    rf_biphase_tx_encoder i_dut (.sys_clk, .srst, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
        .pll_locked(locked), .prdata, .pready, .pslverr, .encoder_out(enc), .pa_enable(pa), .resume_event(res));
    pll_partner i_pll (.sys_clk, .lose_lock, .pll_locked(locked));
    initial forever #20 sys_clk = ~sys_clk;
    task check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task complete_run;
        if (fail_count == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // one apb transfer, held until pready
    task apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge sys_clk) penable <= 1;
        n = 0;
        do begin @(posedge sys_clk); n++; end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin fail_count++; complete_run; end
        psel <= 0;
        penable <= 0;
        @(posedge sys_clk);
    endtask
    task rd(input logic [9:0] idx, input logic [7:0] e);
        exp_q.push_back(e);
        apb(0, idx, 8'h00);
    endtask
    // read data compared against the oldest note
    always @(posedge sys_clk) if (psel && penable && pready === 1'b1 && !pwrite) check(prdata[7:0], exp_q.pop_front());
    always @(posedge sys_clk) if (psel && penable && pready === 1'b1) check({7'h0, pslverr}, 8'h00);
    // line sampled mid-half for every bit of a loaded byte
    always @(posedge sys_clk) if (res === 1'b1) begin
        repeat (2) @(posedge sys_clk);
        for (int k = 7; k >= 0; k--) begin
            seen2[k + 8] = enc;
            repeat (4) @(posedge sys_clk);
            seen2[k] = enc;
            if (k > 0) repeat (4) @(posedge sys_clk);
        end
        e2 = dat_q.pop_front();
        check(seen2[15:8], e2[15:8]);
        check(seen2[7:0], e2[7:0]);
    end
    initial begin
        n = $urandom(32'h9499);
        repeat (3) @(posedge sys_clk);
        srst <= 0;
        @(posedge sys_clk);
        rd(biphase_tx_pkg::IDX_TX_ENCODER_CONTROL, 8'he0);
        rd(biphase_tx_pkg::IDX_TX_ENCODER_STATUS, 8'h02);
        apb(1, biphase_tx_pkg::IDX_TX_ENCODER_CONTROL, 8'hed);
        // two bytes back to back, the second written while the first is sent
        repeat (2) begin
            b = 8'($urandom);
            dat_q.push_back({b, b});
            apb(1, biphase_tx_pkg::IDX_TX_DATA_BUFFER, b);
        end
        rd(biphase_tx_pkg::IDX_TX_ENCODER_STATUS, 8'h01);
        n = 0;
        while (res !== 1'b1 && n < 300) begin @(negedge sys_clk); n++; end
        check({7'h0, res}, 8'h01);
        repeat (160) @(posedge sys_clk);
        rd(biphase_tx_pkg::IDX_TX_ENCODER_STATUS, 8'h02);
        check({6'h0, enc, pa}, 8'h02);
        // manchester byte with lock monitoring and a lock loss in mid-byte
        apb(1, biphase_tx_pkg::IDX_TRANSMITTER_CONTROL, 8'h80);
        apb(1, biphase_tx_pkg::IDX_TX_ENCODER_CONTROL, 8'he0);
        b = 8'($urandom);
        dat_q.push_back({b, ~b});
        apb(1, biphase_tx_pkg::IDX_TX_DATA_BUFFER, b);
        @(posedge sys_clk);
        check({7'h0, pa}, 8'h01);
        repeat (20) @(posedge sys_clk);
        lose_lock <= 1;
        repeat (5) @(posedge sys_clk);
        check({7'h0, pa}, 8'h00);
        lose_lock <= 0;
        repeat (80) @(posedge sys_clk);
        rd(biphase_tx_pkg::IDX_TX_ENCODER_STATUS, 8'h82);
        apb(1, biphase_tx_pkg::IDX_TX_ENCODER_STATUS, 8'h00);
        rd(biphase_tx_pkg::IDX_TX_ENCODER_STATUS, 8'h02);
        check(8'(dat_q.size()), 8'h00);
        // manual amplifier control, as the debug routing needs it
        apb(1, biphase_tx_pkg::IDX_TRANSMITTER_CONTROL, 8'h01);
        @(posedge sys_clk);
        check({6'h0, enc, pa}, 8'h01);
        complete_run;
    end
endmodule
`default_nettype wire
